// *** src/frpm_pkg.sv ***
// package: constants and types for the flash read map and protection block
`default_nettype none
package frpm_pkg;
   // ==========================================================
   // flash control register values
   localparam logic [7:0] FRPM_CTL_RST = 8'h00;
   localparam logic [7:0] FRPM_CTL_XROW = 8'h01;
   localparam logic [7:0] FRPM_CTL_SECB = 8'h04;
   localparam logic [7:0] FRPM_CTL_FUSE = 8'h05;
   // ==========================================================
   // alternate control register fields
   localparam logic [7:0] FRPM_ALT_RST = 8'h00;
   localparam int FRPM_ALT_LSM_BIT = 0;
   localparam int FRPM_ALT_BANK_LSB = 4;
   // ==========================================================
   // security and fuse bytes (lock bits and boot vector in low bits)
   localparam logic [7:0] FRPM_SEC_RST = 8'hfb; // level 4, lock bit 2 = 0
   localparam logic [7:0] FRPM_FUSE_RST = 8'hff;
   localparam logic [2:0] FRPM_BVC_BOOT = 3'b011;
   // ==========================================================
   // address figures
   localparam logic [15:0] FRPM_XROW_TOP = 16'h007f;
   localparam logic [15:0] FRPM_BYTE_ADDR = 16'h0000;
   localparam logic [15:0] FRPM_UPPER_BASE = 16'h8000;
   localparam logic [15:0] FRPM_BOOT_ENTRY = 16'h0000;
   localparam logic [7:0] FRPM_BLOCKED_DATA = 8'hff;
   // ==========================================================
   // strap settle time: two synchroniser stages plus one
   localparam logic [1:0] FRPM_STRAP_CYC = 2'h3;
   // ==========================================================
   // controller register offsets
   localparam logic [3:0] FRPM_REG_CTL = 4'h0;
   localparam logic [3:0] FRPM_REG_ALT = 4'h1;
   localparam logic [3:0] FRPM_REG_STA = 4'h2;
   localparam logic [3:0] FRPM_REG_ALO = 4'h3;
   localparam logic [3:0] FRPM_REG_AHI = 4'h4;
   localparam logic [3:0] FRPM_REG_CMD = 4'h5;
   localparam logic [3:0] FRPM_REG_WDAT = 4'h6;
   localparam logic [3:0] FRPM_REG_RDAT = 4'h7;
   localparam logic [3:0] FRPM_REG_STAT = 4'h8;
   localparam int FRPM_CMD_READ = 0;
   localparam int FRPM_CMD_WRITE = 1;
   localparam int FRPM_CMD_EXT = 2;
   localparam int FRPM_CMD_HIPC = 3;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      FRPM_T_UFL = 3'b000,
      FRPM_T_XROW = 3'b001,
      FRPM_T_SECB = 3'b010,
      FRPM_T_FUSE = 3'b011,
      FRPM_T_ROM = 3'b100,
      FRPM_T_EXT = 3'b101,
      FRPM_T_BLK = 3'b110
   } frpm_tgt_t;
   typedef enum logic [1:0] {
      FRPM_L_NONE = 2'b00,
      FRPM_L_PRI = 2'b01,
      FRPM_L_DBG = 2'b10
   } frpm_link_t;
endpackage
`default_nettype wire

// *** src/frpm_if.sv ***
// interface: core to device access port
`default_nettype none
interface frpm_if;
   logic ctl_wr; // flash_control_reg write strobe
   logic alt_wr; // flash_ctl_reg_alt write strobe
   logic sta_wr; // flash_status_reg write strobe
   logic [7:0] wdata; // data for any write strobe
   logic cread; // code_space_read request
   logic dwr; // data-space write request
   logic [15:0] addr; // data_pointer value
   logic pc_ext; // request issued by code from external memory
   logic pc_hi; // issuing program counter at or above 0x8000
   logic rvalid; // read answer pulse
   logic [7:0] rdata; // read answer byte
   logic boot_mode; // boot process active
   logic [7:0] lock_level; // one-hot protection level 1..4 in bits 0..3
   modport dev (input ctl_wr, alt_wr, sta_wr, wdata, cread, dwr, addr,
      pc_ext, pc_hi, output rvalid, rdata, boot_mode, lock_level);
   modport core (output ctl_wr, alt_wr, sta_wr, wdata, cread, dwr, addr,
      pc_ext, pc_hi, input rvalid, rdata, boot_mode, lock_level);
endinterface
`default_nettype wire

// *** src/frpm_sync.sv ***
// two-flop synchroniser for pins
`default_nettype none
module frpm_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   // ==========================================================
   // first stage feeds only the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= RST;
         q_o <= RST;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule
`default_nettype wire

// *** src/frpm_device.sv ***
// device end: code-space read steering, lock levels and boot selection
//
// Decided for this implementation: the register addresses and strobed register access.
`default_nettype none
module frpm_device (
   input wire logic clk_i,
   input wire logic rst_n_i,
   frpm_if.dev bus,
   input wire logic external_access_pin_i,
   input wire logic program_store_strobe_n_i,
   input wire logic pri_rx_i,
   input wire logic dbg_rx_i,
   input wire logic sec_wr_i,
   input wire logic fcb_wr_i,
   input wire logic [7:0] byte_wdata_i,
   input wire logic [7:0] mem_rdata_i,
   output frpm_pkg::frpm_tgt_t mem_sel_o,
   output logic [18:0] mem_addr_o,
   output logic mem_rd_o,
   output logic latch_wr_o,
   output logic xram_wr_o,
   output logic [15:0] dwr_addr_o,
   output logic [7:0] dwr_data_o,
   output logic start_valid_o,
   output logic [15:0] start_addr_o,
   output logic start_rom_o,
   output frpm_pkg::frpm_link_t link_sel_o,
   output logic par_prog_dis_o,
   output logic isp_write_dis_o,
   output logic par_verify_dis_o,
   output logic isp_read_dis_o,
   output logic ext_exec_dis_o,
   output logic [7:0] security_byte_o,
   output logic [7:0] fuse_config_byte_o
);
   import frpm_pkg::*;

   typedef struct packed {
      logic [1:0] strap_cnt;
      logic started;
      logic boot;
      logic acc_lat;
      logic [7:0] ctl;
      logic [7:0] alt;
      logic remap;
      logic [7:0] sec;
      logic [7:0] fuse;
      logic pend;
      frpm_tgt_t tgt;
      logic [18:0] maddr;
      logic rv;
      logic [7:0] rdata;
      logic lwr;
      logic xwr;
      logic [15:0] daddr;
      logic [7:0] ddata;
      frpm_link_t link;
      logic poll_dbg;
      logic [1:0] rx_prev;
      logic [1:0] rx_fell;
   } frpm_dev_t;

   localparam frpm_dev_t DEV_RST = '{
      strap_cnt: 2'h0, started: 1'b0, boot: 1'b0, acc_lat: 1'b0,
      ctl: FRPM_CTL_RST, alt: FRPM_ALT_RST, remap: 1'b0,
      sec: FRPM_SEC_RST, fuse: FRPM_FUSE_RST, pend: 1'b0,
      tgt: FRPM_T_UFL, maddr: 19'h00000, rv: 1'b0, rdata: 8'h00,
      lwr: 1'b0, xwr: 1'b0, daddr: 16'h0000, ddata: 8'h00,
      link: FRPM_L_NONE, poll_dbg: 1'b0, rx_prev: 2'h3, rx_fell: 2'h0};

   frpm_dev_t s_r;
   frpm_dev_t s_nxt;
   logic acc_s;
   logic strobe_n_s;
   logic [1:0] rx_s;
   logic [1:0] rx_fall;
   logic [2:0] lockb;
   logic lvl2;
   logic lvl3;
   logic lvl4;
   logic acc_eff;
   logic [2:0] bank;
   frpm_tgt_t tgt;

   // ==========================================================
   // pin synchronisers
   frpm_sync #(.W(2), .RST(2'h3)) u_sync_pins (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({external_access_pin_i, program_store_strobe_n_i}),
      .q_o({acc_s, strobe_n_s})
   );
   frpm_sync #(.W(2), .RST(2'h3)) u_sync_rx (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({dbg_rx_i, pri_rx_i}),
      .q_o(rx_s)
   );

   // ==========================================================
   // lock level decode, programmed bit reads as zero
   assign lockb = s_r.sec[2:0];
   assign lvl4 = !lockb[2];
   assign lvl3 = lvl4 || !lockb[1];
   assign lvl2 = lvl3 || !lockb[0];
   assign acc_eff = lvl2 ? s_r.acc_lat : acc_s;
   assign bank = s_r.alt[FRPM_ALT_BANK_LSB +: 3];
   assign rx_fall = s_r.rx_fell | (s_r.rx_prev & ~rx_s);

   // ==========================================================
   // code-space read target choice, highest priority first
   always_comb begin
      if (!acc_eff) begin
         tgt = FRPM_T_EXT;
      end else if (bus.pc_ext && bus.pc_hi && bus.addr >= FRPM_UPPER_BASE)
      begin
         tgt = lvl4 ? FRPM_T_BLK : FRPM_T_EXT;
      end else if (bus.pc_ext) begin
         tgt = FRPM_T_BLK;
      end else if (s_r.boot && !s_r.remap) begin
         tgt = FRPM_T_ROM;
      end else if (s_r.ctl == FRPM_CTL_XROW && bus.addr <= FRPM_XROW_TOP)
      begin
         tgt = FRPM_T_XROW;
      end else if (s_r.ctl == FRPM_CTL_SECB && bus.addr == FRPM_BYTE_ADDR)
      begin
         tgt = FRPM_T_SECB;
      end else if (s_r.ctl == FRPM_CTL_FUSE && bus.addr == FRPM_BYTE_ADDR)
      begin
         tgt = FRPM_T_FUSE;
      end else begin
         tgt = FRPM_T_UFL;
      end
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.rv = 1'b0;
      s_nxt.lwr = 1'b0;
      s_nxt.xwr = 1'b0;
      // strap capture after the synchronisers settle
      if (!s_r.started) begin
         if (s_r.strap_cnt == FRPM_STRAP_CYC) begin
            s_nxt.started = 1'b1;
            s_nxt.acc_lat = acc_s;
            s_nxt.boot = (acc_s && !strobe_n_s)
               || s_r.fuse[2:0] == FRPM_BVC_BOOT;
         end else begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
         end
      end
      // register writes from the core, and security and fuse byte writes from sec_wr_i and fcb_wr_i
      if (bus.ctl_wr) begin
         s_nxt.ctl = bus.wdata;
      end
      if (bus.alt_wr) begin
         s_nxt.alt = bus.wdata;
      end
      if (bus.sta_wr) begin
         s_nxt.remap = bus.wdata[0];
      end
      if (sec_wr_i) begin
         s_nxt.sec = byte_wdata_i;
      end
      if (fcb_wr_i) begin
         s_nxt.fuse = byte_wdata_i;
      end
      // read: take request, then answer from memory, a held byte or the blocked byte
      s_nxt.pend = bus.cread && s_r.started;
      if (bus.cread && s_r.started) begin
         s_nxt.tgt = tgt;
         if (tgt == FRPM_T_ROM) begin
            s_nxt.remap = s_r.remap;
         end else begin
            s_nxt.remap = 1'b0; // one-shot remap
         end
         if (tgt == FRPM_T_UFL && bus.addr >= FRPM_UPPER_BASE) begin
            s_nxt.maddr = {bank, bus.addr};
         end else begin
            s_nxt.maddr = {3'h0, bus.addr};
         end
      end
      if (s_r.pend) begin
         s_nxt.rv = 1'b1;
         unique case (s_r.tgt)
            FRPM_T_SECB: s_nxt.rdata = s_r.sec;
            FRPM_T_FUSE: s_nxt.rdata = s_r.fuse;
            FRPM_T_BLK: s_nxt.rdata = FRPM_BLOCKED_DATA;
            default: s_nxt.rdata = mem_rdata_i;
         endcase
      end
      // data-space write steering
      if (bus.dwr) begin
         s_nxt.daddr = bus.addr;
         s_nxt.ddata = bus.wdata;
         if (s_r.alt[FRPM_ALT_LSM_BIT] && acc_eff && !bus.pc_ext) begin
            s_nxt.lwr = 1'b1;
         end else begin
            s_nxt.xwr = 1'b1;
         end
      end
      // link polling, primary then debug; a fall waits for its turn
      s_nxt.rx_prev = rx_s;
      s_nxt.rx_fell = rx_fall;
      if (s_r.started && s_r.boot && s_r.link == FRPM_L_NONE) begin
         s_nxt.poll_dbg = !s_r.poll_dbg;
         if (!s_r.poll_dbg && rx_fall[0]) begin
            s_nxt.link = FRPM_L_PRI;
         end else if (s_r.poll_dbg && rx_fall[1]) begin
            s_nxt.link = FRPM_L_DBG;
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= DEV_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign mem_sel_o = s_r.tgt;
   assign mem_addr_o = s_r.maddr;
   assign mem_rd_o = s_r.pend;
   assign latch_wr_o = s_r.lwr;
   assign xram_wr_o = s_r.xwr;
   assign dwr_addr_o = s_r.daddr;
   assign dwr_data_o = s_r.ddata;
   assign start_valid_o = s_r.started;
   assign start_addr_o = FRPM_BOOT_ENTRY;
   assign start_rom_o = s_r.boot;
   assign link_sel_o = s_r.link;
   assign par_prog_dis_o = lvl2;
   assign isp_write_dis_o = lvl2;
   assign par_verify_dis_o = lvl3;
   assign isp_read_dis_o = lvl3;
   assign ext_exec_dis_o = lvl4;
   assign security_byte_o = s_r.sec;
   assign fuse_config_byte_o = s_r.fuse;
   assign bus.rvalid = s_r.rv;
   assign bus.rdata = s_r.rdata;
   assign bus.boot_mode = s_r.boot;
   assign bus.lock_level = {4'h0, lvl4, lvl3 && !lvl4, lvl2 && !lvl3,
      !lvl2};
endmodule
`default_nettype wire

// *** src/frpm_core.sv ***
// core end: software register port turned into device accesses
`default_nettype none
module frpm_core (
   input wire logic clk_i,
   input wire logic rst_n_i,
   frpm_if.core bus,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o
);
   import frpm_pkg::*;

   typedef struct packed {
      logic [15:0] ptr;
      logic ext;
      logic hipc;
      logic busy;
      logic [7:0] rres;
      logic [7:0] rdata;
      logic ctl_wr;
      logic alt_wr;
      logic sta_wr;
      logic cread;
      logic dwr;
      logic [7:0] wdat;
   } frpm_core_t;

   localparam frpm_core_t CORE_RST = '{
      ptr: 16'h0000, ext: 1'b0, hipc: 1'b0, busy: 1'b0, rres: 8'h00,
      rdata: 8'h00, ctl_wr: 1'b0, alt_wr: 1'b0, sta_wr: 1'b0,
      cread: 1'b0, dwr: 1'b0, wdat: 8'h00};

   frpm_core_t s_r;
   frpm_core_t s_nxt;

   // ==========================================================
   // next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.ctl_wr = 1'b0;
      s_nxt.alt_wr = 1'b0;
      s_nxt.sta_wr = 1'b0;
      s_nxt.cread = 1'b0;
      s_nxt.dwr = 1'b0;
      s_nxt.rdata = 8'h00;
      if (wr_i) begin
         s_nxt.wdat = wdata_i;
         unique case (addr_i)
            FRPM_REG_CTL: s_nxt.ctl_wr = 1'b1;
            FRPM_REG_ALT: s_nxt.alt_wr = 1'b1;
            FRPM_REG_STA: s_nxt.sta_wr = 1'b1;
            FRPM_REG_ALO: s_nxt.ptr[7:0] = wdata_i;
            FRPM_REG_AHI: s_nxt.ptr[15:8] = wdata_i;
            FRPM_REG_CMD: begin
               s_nxt.ext = wdata_i[FRPM_CMD_EXT];
               s_nxt.hipc = wdata_i[FRPM_CMD_HIPC];
               s_nxt.cread = wdata_i[FRPM_CMD_READ] && !s_r.busy;
               s_nxt.busy = s_r.busy || wdata_i[FRPM_CMD_READ];
               s_nxt.dwr = wdata_i[FRPM_CMD_WRITE];
               s_nxt.wdat = s_r.wdat;
            end
            FRPM_REG_WDAT: s_nxt.wdat = wdata_i;
            default: s_nxt.wdat = s_r.wdat;
         endcase
      end
      if (bus.rvalid) begin
         s_nxt.rres = bus.rdata;
         s_nxt.busy = 1'b0;
      end
      if (rd_i) begin
         unique case (addr_i)
            FRPM_REG_ALO: s_nxt.rdata = s_r.ptr[7:0];
            FRPM_REG_AHI: s_nxt.rdata = s_r.ptr[15:8];
            FRPM_REG_RDAT: s_nxt.rdata = s_r.rres;
            FRPM_REG_STAT: s_nxt.rdata = {bus.lock_level[3:0], 2'h0,
               bus.boot_mode, s_r.busy};
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= CORE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign bus.ctl_wr = s_r.ctl_wr;
   assign bus.alt_wr = s_r.alt_wr;
   assign bus.sta_wr = s_r.sta_wr;
   assign bus.wdata = s_r.wdat;
   assign bus.cread = s_r.cread;
   assign bus.dwr = s_r.dwr;
   assign bus.addr = s_r.ptr;
   assign bus.pc_ext = s_r.ext;
   assign bus.pc_hi = s_r.hipc;
   assign rdata_o = s_r.rdata;
endmodule
`default_nettype wire

// *** tb/frpm_checker.sv ***
// checker: timing and protection relations on the core to device link
`default_nettype none
module frpm_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cread,
   input wire logic dwr,
   input wire logic pc_ext,
   input wire logic pc_hi,
   input wire logic [15:0] addr,
   input wire logic rvalid,
   input wire logic [7:0] rdata,
   input wire logic boot_mode,
   input wire logic [7:0] lock_level
);
   // ==========================================================
   // one clock domain, reset disables every check
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // read answer timing
   a_read_answer: assert property (cread |-> ##2 rvalid)
      else $error("read answer not two cycles after request");
   a_answer_cause: assert property (rvalid |-> $past(cread, 2))
      else $error("read answer without a request");
   a_rdata_held: assert property (!rvalid |-> $stable(rdata))
      else $error("read byte changed without an answer");
   // ==========================================================
   // lock level and boot selection
   a_lock_default: assert property ($rose(rst_n_i)
      |-> lock_level == 8'h08)
      else $error("lock level after reset is not four");
   a_lock_onehot: assert property ($onehot(lock_level[3:0])
      && lock_level[7:4] == 4'h0)
      else $error("lock level not a single level");
   a_boot_kept: assert property (!$fell(boot_mode))
      else $error("boot mode dropped outside reset");
   // ==========================================================
   // code read from external memory never sees internal bytes
   a_ext_blocked: assert property (cread && pc_ext && !pc_hi
      |-> ##2 rdata == 8'hff)
      else $error("external code read an internal byte");
   a_ext_exec_off: assert property (cread && pc_ext && pc_hi && addr[15]
      && lock_level[3] |-> ##2 rdata == 8'hff)
      else $error("external bank read at level four");
   // ==========================================================
   // main scenarios
   c_read: cover property (cread && !pc_ext);
   c_write: cover property (dwr);
   c_boot: cover property ($rose(boot_mode));
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench: both ends joined, software port and pins driven
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import frpm_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic acc_pin = 1'b1;
   logic prx = 1'b1;
   logic pss_n = 1'b1;
   logic drx = 1'b1;
   logic sec_wr = 1'b0;
   logic fcb_wr = 1'b0;
   logic [7:0] bwd = 8'h00;
   logic [7:0] rdata_o, mrdat, dwd, sbo, fbo;
   logic [18:0] madr;
   logic [15:0] sadr, dwa;
   logic lwr, xwr, sval, srom, pp, iw, pv, ir, xd, mrp;
   frpm_tgt_t msel;
   frpm_link_t lnk;
   int err_total = 0;
   int n_tests = 0;
   int n_lat = 0;
   int n_xr = 0;
   int n_mr = 0;
   int cyc = 0;
   // memory byte shows bank, target and low address bits
   assign mrdat = {madr[18:16], msel, madr[1:0]};
   always #25 clk_i = ~clk_i;
   // ==========================================================
   // the two ends
   frpm_if i_frpm_if ();
   frpm_core i_frpm_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(i_frpm_if),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o));
   frpm_device i_frpm_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .bus(i_frpm_if), .external_access_pin_i(acc_pin),
      .program_store_strobe_n_i(pss_n), .pri_rx_i(prx), .dbg_rx_i(drx),
      .sec_wr_i(sec_wr), .fcb_wr_i(fcb_wr), .byte_wdata_i(bwd),
      .mem_rdata_i(mrdat), .mem_sel_o(msel), .mem_addr_o(madr),
      .mem_rd_o(mrp), .latch_wr_o(lwr), .xram_wr_o(xwr), .dwr_addr_o(dwa),
      .dwr_data_o(dwd), .start_valid_o(sval), .start_addr_o(sadr),
      .start_rom_o(srom), .link_sel_o(lnk), .par_prog_dis_o(pp),
      .isp_write_dis_o(iw), .par_verify_dis_o(pv), .isp_read_dis_o(ir),
      .ext_exec_dis_o(xd), .security_byte_o(sbo), .fuse_config_byte_o(fbo));
   frpm_checker i_frpm_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cread(i_frpm_if.cread), .dwr(i_frpm_if.dwr),
      .pc_ext(i_frpm_if.pc_ext), .pc_hi(i_frpm_if.pc_hi),
      .addr(i_frpm_if.addr), .rvalid(i_frpm_if.rvalid),
      .rdata(i_frpm_if.rdata), .boot_mode(i_frpm_if.boot_mode),
      .lock_level(i_frpm_if.lock_level));
   // ==========================================================
   // write pulses and memory read pulses counted, run length watched
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (lwr === 1'b1) n_lat <= n_lat + 1;
      if (xwr === 1'b1) n_xr <= n_xr + 1;
      if (mrp === 1'b1) n_mr <= n_mr + 1;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end
   // ==========================================================
   // register port tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      // read byte stands for this one cycle only
      @(negedge clk_i);
      d = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic st(input logic [7:0] e);
      logic [7:0] d;
      rd(FRPM_REG_STAT, d);
      chk(d, e);
   endtask
   // code-space read: flags bit2 external code, bit3 upper counter
   task automatic mrd(input logic [3:0] f, input logic [15:0] p,
         input logic [7:0] e);
      logic [7:0] d;
      wr(FRPM_REG_ALO, p[7:0]);
      wr(FRPM_REG_AHI, p[15:8]);
      wr(FRPM_REG_CMD, {4'h0, f} | 8'h01);
      repeat (4) @(posedge clk_i);
      rd(FRPM_REG_RDAT, d);
      chk(d, e);
   endtask
   task automatic mapchk(input logic [7:0] c, input logic [15:0] p,
         input logic [7:0] e);
      wr(FRPM_REG_CTL, c);
      mrd(4'h0, p, e);
   endtask
   task automatic dw(input logic [3:0] f);
      wr(FRPM_REG_WDAT, 8'h3c);
      wr(FRPM_REG_CMD, {4'h0, f} | 8'h02);
      repeat (4) @(posedge clk_i);
   endtask
   // reset, optionally loading boot vector 011 before strap capture
   task automatic rst(input logic fz);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      if (fz) begin
         @(posedge clk_i);
         fcb_wr <= 1'b1;
         bwd <= 8'hf3;
         @(posedge clk_i);
         fcb_wr <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
      chk({7'h0, sval}, 8'h01);
      chk(sadr[15:8] | sadr[7:0], 8'h00);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      logic [7:0] lv [4] = '{8'hfb, 8'hfd, 8'hfe, 8'hff};
      logic [7:0] sv [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
      logic [7:0] dv [4] = '{8'h1f, 8'h0f, 8'h03, 8'h00};
      rst(1'b0);
      st(8'h80);
      chk({7'h0, srom}, 8'h00);
      mrd(4'h0, 16'h0013, 8'h03);
      for (int b = 0; b < 8; b++) begin
         wr(FRPM_REG_ALT, {1'b0, 3'(b), 4'h0});
         mrd(4'h0, 16'h8001, {3'(b), 5'h01});
      end
      chk(8'(n_mr), 8'h09);
      wr(FRPM_REG_ALT, FRPM_ALT_RST);
      mapchk(FRPM_CTL_XROW, 16'h007f, 8'h07);
      mapchk(FRPM_CTL_XROW, 16'h0080, 8'h00);
      mapchk(FRPM_CTL_SECB, 16'h0000, 8'hfb);
      mapchk(FRPM_CTL_FUSE, 16'h0000, 8'hff);
      mapchk(FRPM_CTL_RST, 16'h0002, 8'h02);
      mrd(4'h4, 16'h0001, 8'hff);
      mrd(4'hc, 16'h8001, 8'hff);
      dw(4'h0);
      wr(FRPM_REG_ALT, 8'h01);
      dw(4'h0);
      dw(4'h4);
      chk(8'(n_lat), 8'h01);
      chk(8'(n_xr), 8'h02);
      chk(dwd, 8'h3c);
      chk(dwa[15:8], 8'h80);
      wr(FRPM_REG_ALT, FRPM_ALT_RST);
      // access pin latched at level four: a drop is ignored
      acc_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      mrd(4'h0, 16'h0003, 8'h03);
      acc_pin <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         sec_wr <= 1'b1;
         bwd <= lv[i];
         @(posedge clk_i);
         sec_wr <= 1'b0;
         st(sv[i]);
         chk(sbo, lv[i]);
         chk({3'h0, xd, ir, pv, iw, pp}, dv[i]);
      end
      mrd(4'hc, 16'h8002, 8'h16);
      acc_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      mrd(4'h0, 16'h0003, 8'h17);
      acc_pin <= 1'b1;
      pss_n <= 1'b0;
      rst(1'b0);
      pss_n <= 1'b1;
      st(8'h82);
      chk({7'h0, srom}, 8'h01);
      mrd(4'h0, 16'h0001, 8'h11);
      wr(FRPM_REG_STA, 8'h01);
      mrd(4'h0, 16'h0001, 8'h01);
      mrd(4'h0, 16'h0001, 8'h11);
      drx <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({6'h0, lnk}, {6'h0, FRPM_L_DBG});
      drx <= 1'b1;
      rst(1'b1);
      st(8'h82);
      chk(fbo, 8'hf3);
      chk({6'h0, lnk}, {6'h0, FRPM_L_NONE});
      prx <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({6'h0, lnk}, {6'h0, FRPM_L_PRI});
      summarize();
   end
endmodule
`default_nettype wire
